/* File: adc_port_consts.svh */
// Constants shared by the result output port and its buffer.
// Assumes one system clock of 200 MHz; the link runs on the host's strobe.
//
// Summary of operation
// RQ1: Parallel mode: bit-7 pin floats except while select and read are low.
// RQ2: Parallel mode: bit-8 pin carries result bit 8 during a read.
// RQ3: Parallel mode: bits 13 to 9 driven during a read.
// RQ4: Board grounds bits 13 to 9 when interface select is high.
// RQ5: Parallel mode: result bit 14 leaves on the high-byte-first pin.
// RQ6: Parallel mode: result bit 15 leaves on the byte-select pin.
// RQ7: Serial mode: bit-7 pin is serial output A, bit-8 pin output B.
// RQ8: Mode from straps: low parallel, high+low serial, high+high byte.
// RQ9: Byte mode: high-byte-first set sends upper byte first, else lower.
// RQ10: Byte mode: bytes on low eight pins, bit-7 pin is byte MSB.
// RQ11: Board grounds the high-byte-first pin in serial mode.
// RQ12: Reference select high enables internal reference, low disables it.
// RQ13: Byte mode: each result takes two consecutive reads, bit 0 is LSB.
// RQ14: Serial: select fall presents MSB, each clock rise shifts next bit.
// RQ15: Parallel mode: bits 6 to 0 driven during a read.
// RQ16: Reads return channels in ascending order from channel one.
// RQ17: Parallel or byte mode: used pins float while select or read high.
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

`define RES_W 16
`define NCHAN 8
`define CHAN_W 3
`define CHAN_ONE 3'h1
`define CHAN_FIRST 3'h0
`define LAST_CHAN 3'h7
`define CNT_W 6
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01
`define ALL_OFF 16'hFFFF
`define ALL_ZERO 16'h0000
`define RES_ZERO 16'h0000
`define BIT_A 7
`define BIT_B 8
`define BIT_HBF 14
`define BIT_BSEL 15
`define SYNC_W 5
`define SY_CS 0
`define SY_IF 1
`define SY_BS 2
`define SY_HB 3
`define SY_REF 4
`define SYNC_RST 5'h01
`define BUF_CNT_W 2
`define BUF_EMPTY 2'h0
`define BUF_ONE 2'h1
`define BUF_FULL 2'h2

`endif

/* File: adc_port_pkg.sv */
// Types shared by the result output port and its buffer.
// Assumes the constants header is on the include path.
`include "adc_port_consts.svh"

package adc_port_pkg;

  typedef logic [`RES_W-1:0] result_t;

  typedef enum logic [1:0] {
    MODE_PAR = 2'b00,
    MODE_SER = 2'b01,
    MODE_BYTE = 2'b10
  } mode_e;

  typedef enum logic [1:0] {
    ST_FILL = 2'b00,
    ST_FULL = 2'b01,
    ST_READ = 2'b10
  } fill_state_e;

  // Interface mode from the two straps
  function automatic mode_e decode_mode(input logic iface, input logic bsel);
    if (!iface) begin
      return MODE_PAR;
    end
    return bsel ? MODE_BYTE : MODE_SER;
  endfunction : decode_mode

endpackage : adc_port_pkg

/* File: adc_result_output_port.sv */
// Result output port: gathers eight channel results into a frame bank
// and hands them to the host over the shared parallel/serial/byte pins.
// Assumes the conversion core delivers results in channel order 1..8 and
// that the host starts a frame only while FRAME_READY is high.
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module adc_result_output_port (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RES_VALID,
  input adc_port_pkg::result_t RES_DATA,
  output logic RES_READY,
  output logic FRAME_READY,
  input wire logic IFACE_SEL,
  input wire logic RD_SCLK,
  input wire logic CS_N,
  input wire logic [`RES_W-1:0] PRB_I,
  output logic [`RES_W-1:0] PRB_O,
  output logic [`RES_W-1:0] PRB_OE_N,
  input wire logic REF_SEL,
  output logic INT_REF_EN
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`SYNC_W-1:0] sync1_q, sync1_d;
  logic [`SYNC_W-1:0] sync2_q, sync2_d;
  logic cs_s;

  mode_e mode_q, mode_d;
  logic hbf_q, hbf_d;
  logic ref_q, ref_d;

  fill_state_e state_q, state_d;
  logic [`CHAN_W-1:0] fill_q, fill_d;
  result_t bank_q [`NCHAN];
  result_t bank_d [`NCHAN];
  logic pop_rdy;

  logic link_rst_n;
  logic [`CNT_W-1:0] cnt_q, cnt_d;

  result_t par_word;
  result_t byte_word;
  logic upper;
  logic ser_a;
  logic ser_b;
  logic drive_n;
  logic [`RES_W-1:0] pin_o;
  logic [`RES_W-1:0] pin_oe_n;

  result_buf_if rb ();

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  // A stalled frame bank pushes back through the buffer to the core
  assign rb.in_valid = RES_VALID;
  assign rb.in_data = RES_DATA;
  assign rb.out_ready = pop_rdy;
  assign RES_READY = rb.in_ready;

  result_buf u_buf (
    .CLK(CLK),
    .RST_N(RST_N),
    .rb(rb)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    sync1_d[`SY_CS] = CS_N;
    sync1_d[`SY_IF] = IFACE_SEL;
    sync1_d[`SY_BS] = PRB_I[`BIT_BSEL];
    sync1_d[`SY_HB] = PRB_I[`BIT_HBF];
    sync1_d[`SY_REF] = REF_SEL;
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= `SYNC_RST;
      sync2_q <= `SYNC_RST;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign cs_s = sync2_q[`SY_CS];

  // ----------------------------------------------------------------
  // Straps and reference select
  // ----------------------------------------------------------------
  // Straps are taken only between frames so the link sees a steady mode
  always_comb begin
    mode_d = mode_q;
    hbf_d = hbf_q;
    if (cs_s) begin
      mode_d = decode_mode(sync2_q[`SY_IF], sync2_q[`SY_BS]); // [RQ8]
      hbf_d = sync2_q[`SY_HB]; // [RQ9]
    end
    ref_d = sync2_q[`SY_REF]; // [RQ12]
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= MODE_PAR;
      hbf_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      hbf_q <= hbf_d;
      ref_q <= ref_d;
    end
  end

  assign INT_REF_EN = ref_q; // [RQ12]

  // ----------------------------------------------------------------
  // Frame bank fill
  // ----------------------------------------------------------------
  // The bank is written only before a frame; the link reads it while
  // the frame runs, so nothing in it moves under the host's strobes.
  always_comb begin
    state_d = state_q;
    fill_d = fill_q;
    bank_d = bank_q;
    pop_rdy = 1'b0;
    unique case (state_q)
      ST_FILL: begin
        pop_rdy = 1'b1;
        if (rb.out_valid) begin
          bank_d[fill_q] = rb.out_data; // [RQ16]
          fill_d = fill_q + `CHAN_ONE;
          if (fill_q == `LAST_CHAN) begin
            state_d = ST_FULL;
          end
        end
      end
      ST_FULL: begin
        if (!cs_s) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (cs_s) begin
          state_d = ST_FILL;
          fill_d = `CHAN_FIRST;
        end
      end
      default: begin
        state_d = ST_FILL;
        fill_d = `CHAN_FIRST;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_FILL;
      fill_q <= `CHAN_FIRST;
      for (int i = 0; i < `NCHAN; i++) begin
        bank_q[i] <= `RES_ZERO;
      end
    end else begin
      state_q <= state_d;
      fill_q <= fill_d;
      bank_q <= bank_d;
    end
  end

  assign FRAME_READY = (state_q == ST_FULL);

  // ----------------------------------------------------------------
  // Link-side read counter
  // ----------------------------------------------------------------
  // Chip select high holds the counter at zero, so the select fall
  // presents channel one and the MSB with no strobe edge needed.
  assign link_rst_n = RST_N & ~CS_N; // [RQ14]

  always_comb begin
    cnt_d = cnt_q + `CNT_ONE; // [RQ14] [RQ16]
  end

  always_ff @(posedge RD_SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_q <= `CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Enables follow the select and strobe pins directly: a synchroniser
  // here would open the bus late and keep it open past the read.
  always_comb begin
    par_word = bank_q[cnt_q[`CHAN_W-1:0]]; // [RQ16]
    byte_word = bank_q[cnt_q[`CHAN_W:1]]; // [RQ13]
    upper = hbf_q ? ~cnt_q[0] : cnt_q[0]; // [RQ9]
    ser_a = bank_q[{1'b0, cnt_q[5:4]}][~cnt_q[3:0]]; // [RQ14]
    ser_b = bank_q[{1'b1, cnt_q[5:4]}][~cnt_q[3:0]]; // [RQ14]
    if (mode_q == MODE_SER) begin
      drive_n = CS_N;
    end else begin
      drive_n = CS_N | RD_SCLK; // [RQ17]
    end
    pin_o = `ALL_ZERO;
    pin_oe_n = `ALL_OFF;
    unique case (mode_q)
      MODE_PAR: begin
        pin_o = par_word; // [RQ1] [RQ2] [RQ3] [RQ5] [RQ6] [RQ15]
        pin_oe_n = {`RES_W{drive_n}}; // [RQ1] [RQ17]
      end
      MODE_BYTE: begin
        // Upper byte keeps bit 15 on the bit-7 pin [RQ10]
        pin_o[7:0] = upper ? byte_word[15:8] : byte_word[7:0]; // [RQ13]
        pin_oe_n[7:0] = {8{drive_n}}; // [RQ10] [RQ17]
      end
      MODE_SER: begin
        pin_o[`BIT_A] = ser_a; // [RQ7]
        pin_o[`BIT_B] = ser_b; // [RQ7]
        pin_oe_n[`BIT_A] = drive_n;
        pin_oe_n[`BIT_B] = drive_n;
      end
      default: begin
        pin_o = `ALL_ZERO;
        pin_oe_n = `ALL_OFF;
      end
    endcase
  end

  assign PRB_O = pin_o;
  assign PRB_OE_N = pin_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_par_b7_float;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && (CS_N || RD_SCLK)) |-> PRB_OE_N[`BIT_A];
  endproperty
  a_par_b7_float: assert property (p_par_b7_float) else $error("bit7 driven idle"); // [RQ1]

  property p_par_b8;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && !CS_N && !RD_SCLK)
      |-> (!PRB_OE_N[`BIT_B] && PRB_O[`BIT_B] == par_word[`BIT_B]);
  endproperty
  a_par_b8: assert property (p_par_b8) else $error("bit8 not driven"); // [RQ2]

  property p_par_mid;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && !CS_N && !RD_SCLK)
      |-> (PRB_OE_N[13:9] == 5'h00 && PRB_O[13:9] == par_word[13:9]);
  endproperty
  a_par_mid: assert property (p_par_mid) else $error("bits 13:9 wrong"); // [RQ3]

  property p_par_b14;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && !CS_N && !RD_SCLK)
      |-> (!PRB_OE_N[`BIT_HBF] && PRB_O[`BIT_HBF] == par_word[`BIT_HBF]);
  endproperty
  a_par_b14: assert property (p_par_b14) else $error("bit14 wrong"); // [RQ5]

  property p_par_b15;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && !CS_N && !RD_SCLK)
      |-> (!PRB_OE_N[`BIT_BSEL] && PRB_O[`BIT_BSEL] == par_word[`BIT_BSEL]);
  endproperty
  a_par_b15: assert property (p_par_b15) else $error("bit15 wrong"); // [RQ6]

  property p_par_low;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_PAR && !CS_N && !RD_SCLK)
      |-> (PRB_OE_N[6:0] == 7'h00 && PRB_O[6:0] == par_word[6:0]);
  endproperty
  a_par_low: assert property (p_par_low) else $error("bits 6:0 wrong"); // [RQ15]

  property p_ser_pins;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_SER && !CS_N)
      |-> (!PRB_OE_N[`BIT_A] && !PRB_OE_N[`BIT_B]
           && PRB_OE_N[15:9] == 7'h7F && PRB_OE_N[6:0] == 7'h7F);
  endproperty
  a_ser_pins: assert property (p_ser_pins) else $error("serial pins wrong"); // [RQ7]

  property p_mode_decode;
    @(posedge CLK) disable iff (!RST_N)
    cs_s |=> mode_q == decode_mode($past(sync2_q[`SY_IF]), $past(sync2_q[`SY_BS]));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong"); // [RQ8]

  property p_byte_order;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_BYTE && !CS_N && !RD_SCLK && cnt_q[0] == 1'b0)
      |-> PRB_O[7:0] == (hbf_q ? byte_word[15:8] : byte_word[7:0]);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("byte order wrong"); // [RQ9]

  property p_byte_pins;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_BYTE && !CS_N && !RD_SCLK)
      |-> (PRB_OE_N[7:0] == 8'h00 && PRB_OE_N[15:8] == 8'hFF);
  endproperty
  a_byte_pins: assert property (p_byte_pins) else $error("byte pins wrong"); // [RQ10]

  property p_ref_follow;
    @(posedge CLK) disable iff (!RST_N)
    $rose(REF_SEL) ##0 REF_SEL [*3] |=> INT_REF_EN;
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("ref enable late"); // [RQ12]

  property p_ser_msb;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q == MODE_SER && CS_N [*2] ##1 !CS_N)
      |-> PRB_O[`BIT_A] == bank_q[0][`RES_W-1];
  endproperty
  a_ser_msb: assert property (p_ser_msb) else $error("serial MSB missing"); // [RQ14]

  property p_fill_order;
    @(posedge CLK) disable iff (!RST_N)
    (state_q == ST_FILL && rb.out_valid)
      |=> (fill_q == 3'($past(fill_q) + `CHAN_ONE)
           && bank_q[$past(fill_q)] == $past(rb.out_data));
  endproperty
  a_fill_order: assert property (p_fill_order) else $error("fill order wrong"); // [RQ16]

  property p_idle_float;
    @(posedge CLK) disable iff (!RST_N)
    (mode_q != MODE_SER && (CS_N || RD_SCLK)) |-> PRB_OE_N == `ALL_OFF;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("bus driven idle"); // [RQ17]

endmodule : adc_result_output_port

/* File: host_link_model.sv */
// Host model for the result output port: straps, chip select, and a 32 ns
// read strobe or serial clock that stands still high between frames.
// Assumes the bench calls its tasks one at a time, hierarchically.
`timescale 1ns/1ps

module host_link_model (
  output logic IFACE_SEL,
  output logic CS_N,
  output logic RD_SCLK,
  output adc_port_pkg::result_t PRB_I,
  input wire logic [15:0] PRB_O,
  input wire logic [15:0] PRB_OE_N
);
  import adc_port_pkg::*;
  logic bsel_q;
  logic hbf_q;
  result_t host_en;
  result_t samp_o [$];
  result_t samp_oe [$];
  result_t idle_oe [$];

  // Called by the bench at time zero, so one process drives every pin
  task automatic idle;
    IFACE_SEL = 1'b0;
    CS_N = 1'b1;
    RD_SCLK = 1'b1;
    bsel_q = 1'b0;
    hbf_q = 1'b0;
  endtask : idle

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Board grounds pins unused in serial and byte modes
  assign host_en = !IFACE_SEL ? 16'h0000 : (bsel_q ? 16'hFF00 : 16'hFE7F);
  // A released line the board does not hold shows the inverse, so a stale value never passes
  assign PRB_I = (~PRB_OE_N & PRB_O) | (PRB_OE_N & host_en & {bsel_q, hbf_q & bsel_q, 14'h0000})
               | (PRB_OE_N & ~host_en & ~PRB_O);

  task automatic set_straps(input logic iface, input logic bsel, input logic hbf);
    IFACE_SEL = iface;
    bsel_q = bsel;
    hbf_q = hbf;
  endtask : set_straps

  // Samples late in each low half, just before the rising edge
  task automatic frame(input int n);
    samp_o.delete();
    samp_oe.delete();
    idle_oe.delete();
    #3 CS_N = 1'b0;
    #16;
    repeat (n) begin
      RD_SCLK = 1'b0;
      #14 samp_o.push_back(PRB_O);
      samp_oe.push_back(PRB_OE_N);
      #2 RD_SCLK = 1'b1;
      #14 idle_oe.push_back(PRB_OE_N);
      #2;
    end
    CS_N = 1'b1;
  endtask : frame
endmodule : host_link_model

/* File: result_buf.sv */
// Two-entry result buffer with valid and ready on both sides.
// Assumes one clock; the head entry is a register and feeds out_data.
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module result_buf (
  input wire logic CLK,
  input wire logic RST_N,
  result_buf_if.stor rb
);
  import adc_port_pkg::*;

  logic [`BUF_CNT_W-1:0] cnt_q, cnt_d;
  result_t e0_q, e0_d;
  result_t e1_q, e1_d;
  logic push;
  logic pop;

  // No pass-through when full: ready depends on count only, no comb path
  assign rb.in_ready = (cnt_q != `BUF_FULL);
  assign rb.out_valid = (cnt_q != `BUF_EMPTY);
  assign rb.out_data = e0_q;

  always_comb begin
    push = rb.in_valid && (cnt_q != `BUF_FULL);
    pop = rb.out_ready && (cnt_q != `BUF_EMPTY);
    e0_d = e0_q;
    e1_d = e1_q;
    cnt_d = cnt_q;
    if (pop) begin
      e0_d = e1_q;
      cnt_d = cnt_q - `BUF_ONE;
    end
    if (push) begin
      if (cnt_d == `BUF_EMPTY) begin
        e0_d = rb.in_data;
      end else begin
        e1_d = rb.in_data;
      end
      cnt_d = cnt_d + `BUF_ONE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= `BUF_EMPTY;
      e0_q <= `RES_ZERO;
      e1_q <= `RES_ZERO;
    end else begin
      cnt_q <= cnt_d;
      e0_q <= e0_d;
      e1_q <= e1_d;
    end
  end

endmodule : result_buf

/* File: result_buf_if.sv */
// Handshake bundle between the output port and its two-entry buffer.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps

interface result_buf_if;
  logic in_valid;
  logic in_ready;
  adc_port_pkg::result_t in_data;
  logic out_valid;
  logic out_ready;
  adc_port_pkg::result_t out_data;

  modport stor (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface : result_buf_if

/* File: testbench.sv */
// Self-checking bench for the result output port.
// Assumes the host model drives the link pins and straps.
`timescale 1ns/1ps

module testbench;
  import adc_port_pkg::*;
  logic CLK;
  logic RST_N;
  logic RES_VALID;
  result_t RES_DATA;
  logic RES_READY;
  logic FRAME_READY;
  logic IFACE_SEL;
  logic CS_N;
  logic RD_SCLK;
  result_t PRB_I;
  result_t PRB_O;
  result_t PRB_OE_N;
  logic REF_SEL;
  logic INT_REF_EN;
  int n_mismatch;
  int checked;
  int n_acc;
  int fno;

  adc_result_output_port u_dut (.CLK(CLK), .RST_N(RST_N), .RES_VALID(RES_VALID),
    .RES_DATA(RES_DATA), .RES_READY(RES_READY), .FRAME_READY(FRAME_READY),
    .IFACE_SEL(IFACE_SEL), .RD_SCLK(RD_SCLK), .CS_N(CS_N), .PRB_I(PRB_I), .PRB_O(PRB_O),
    .PRB_OE_N(PRB_OE_N), .REF_SEL(REF_SEL), .INT_REF_EN(INT_REF_EN));

  host_link_model u_host (.IFACE_SEL(IFACE_SEL), .CS_N(CS_N), .RD_SCLK(RD_SCLK),
    .PRB_I(PRB_I), .PRB_O(PRB_O), .PRB_OE_N(PRB_OE_N));

  // Distinct bytes in every word make a swapped byte order visible
  function automatic result_t word(input int n);
    return {~n[7:0], n[7:0]};
  endfunction : word

  // ----------------------------------------------------------------
  // Core-side feeder: stalls whenever the port refuses
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RST_N) begin
      n_acc <= 0;
      RES_DATA <= word(0);
    end else if (RES_VALID === 1'b1 && RES_READY === 1'b1) begin
      n_acc <= n_acc + 1;
      RES_DATA <= word(n_acc + 1);
    end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk16(input result_t got, input result_t exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  // Straps change only with chip select high, then settle past the sync
  task automatic start(input logic iface, input logic bsel, input logic hbf);
    int i;
    u_host.set_straps(iface, bsel, hbf);
    repeat (5) @(posedge CLK);
    for (i = 0; i < 400 && FRAME_READY !== 1'b1; i++) @(posedge CLK);
    if (FRAME_READY !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: frame never ready", $time);
      wrap_up();
    end
  endtask : start

  task automatic t_reference;
    @(posedge CLK);
    REF_SEL <= 1'b1;
    @(posedge CLK);
    #1 chk1(INT_REF_EN, 1'b0, "ref early");
    repeat (3) @(posedge CLK);
    #1 chk1(INT_REF_EN, 1'b1, "ref on");
    @(posedge CLK);
    REF_SEL <= 1'b0;
    repeat (4) @(posedge CLK);
    #1 chk1(INT_REF_EN, 1'b0, "ref off");
  endtask : t_reference

  task automatic t_fill;
    start(1'b0, 1'b0, 1'b0);
    repeat (10) @(posedge CLK);
    #1 chk16(result_t'(n_acc), 16'h000A, "accepted");
    chk1(RES_READY, 1'b0, "full refuses");
  endtask : t_fill

  task automatic t_parallel;
    int k;
    start(1'b0, 1'b0, 1'b0);
    u_host.frame(8);
    chk1(FRAME_READY, 1'b0, "frame taken");
    for (k = 0; k < 8; k++) begin
      chk16(u_host.samp_oe[k], 16'h0000, "par oe");
      chk16(u_host.samp_o[k], word(8 * fno + k), "par data");
      chk16(u_host.idle_oe[k], 16'hFFFF, "par idle");
    end
    fno = fno + 1;
  endtask : t_parallel

  task automatic t_byte(input logic hbf);
    int k;
    result_t w;
    logic [7:0] e;
    start(1'b1, 1'b1, hbf);
    u_host.frame(16);
    for (k = 0; k < 16; k++) begin
      w = word(8 * fno + k / 2);
      e = ((k % 2 == 0) == hbf) ? w[15:8] : w[7:0];
      chk16(u_host.samp_oe[k], 16'hFF00, "byte oe");
      chk16({8'h00, u_host.samp_o[k][7:0]}, {8'h00, e}, "byte data");
      chk16(u_host.idle_oe[k], 16'hFFFF, "byte idle");
    end
    fno = fno + 1;
  endtask : t_byte

  task automatic t_serial;
    int k;
    result_t a;
    result_t b;
    start(1'b1, 1'b0, 1'b0);
    u_host.frame(64);
    for (k = 0; k < 64; k++) begin
      a = word(8 * fno + k / 16);
      b = word(8 * fno + 4 + k / 16);
      chk16(u_host.samp_oe[k], 16'hFE7F, "ser oe");
      chk16(u_host.idle_oe[k], 16'hFE7F, "ser hold");
      chk16({14'h0000, u_host.samp_o[k][8], u_host.samp_o[k][7]},
            {14'h0000, b[15 - k % 16], a[15 - k % 16]}, "ser bits");
    end
    // Let the released enables settle after chip select rises
    #1 chk16(PRB_OE_N, 16'hFFFF, "ser release");
    fno = fno + 1;
  endtask : t_serial

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    u_host.idle();
    n_mismatch = 0;
    checked = 0;
    fno = 0;
    RST_N = 1'b0;
    RES_VALID = 1'b0;
    REF_SEL = 1'b0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    RES_VALID <= 1'b1;
    #1 chk1(INT_REF_EN, 1'b0, "ref reset");
    t_reference();
    t_fill();
    t_parallel();
    t_byte(1'b1);
    t_byte(1'b0);
    t_serial();
    t_parallel();
    wrap_up();
  end
endmodule : testbench
